// ==== core/timer_pair_pkg.sv ====
package timer_pair_pkg;
	// register bus geometry
	localparam int DATA_W = 16;
	localparam int ADDR_W = 3;
	localparam int PRIO_W = 3;
	localparam int PS_W = 8;

	// register offsets, one word each
	localparam logic [ADDR_W-1:0] ADDR_LOW_CTL = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_HIGH_CTL = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_LOW_COUNT = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_HIGH_COUNT = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_LOW_PERIOD = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_HIGH_PERIOD = 3'h5;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CTL = 3'h6;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAG = 3'h7;

	// control register field positions
	localparam int RUN_BIT = 15;
	localparam int IDLE_STOP_BIT = 13;
	localparam int GATE_BIT = 6;
	localparam int PS_HI = 5;
	localparam int PS_LO = 4;
	localparam int JOIN_BIT = 3;
	localparam int CLK_SRC_BIT = 1;

	// implemented control bits; the high control has no join bit
	localparam logic [DATA_W-1:0] LOW_CTL_MASK = 16'ha07a;
	localparam logic [DATA_W-1:0] HIGH_CTL_MASK = 16'ha072;
	localparam logic [DATA_W-1:0] CTL_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] COUNT_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] PERIOD_RESET = 16'hffff;
	localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [DATA_W-1:0] WORD_ONE = 16'h0001;

	// interrupt control and flag fields
	localparam int LOW_IE_BIT = 0;
	localparam int HIGH_IE_BIT = 1;
	localparam int LOW_PRIO_LO = 2;
	localparam int HIGH_PRIO_LO = 5;
	localparam int IRQ_CTL_W = 8;
	localparam logic [IRQ_CTL_W-1:0] IRQ_CTL_RESET = 8'h00;
	localparam int FLAG_LOW = 0;
	localparam int FLAG_HIGH = 1;
	localparam logic [1:0] FLAG_RESET = 2'h0;

	// prescale select codes
	typedef enum logic [1:0] {
		PS_DIV1 = 2'h0,
		PS_DIV8 = 2'h1,
		PS_DIV64 = 2'h2,
		PS_DIV256 = 2'h3
	} prescale_t;

	localparam logic [PS_W-1:0] LAST_DIV1 = 8'h00;
	localparam logic [PS_W-1:0] LAST_DIV8 = 8'h07;
	localparam logic [PS_W-1:0] LAST_DIV64 = 8'h3f;
	localparam logic [PS_W-1:0] LAST_DIV256 = 8'hff;

	// last prescaler count before a tick for a select code
	function automatic logic [PS_W-1:0] prescaleLast(input logic [1:0] sel);
		logic [PS_W-1:0] last;
		last = LAST_DIV1;
		case (sel)
			PS_DIV8: last = LAST_DIV8;
			PS_DIV64: last = LAST_DIV64;
			PS_DIV256: last = LAST_DIV256;
			default: last = LAST_DIV1;
		endcase
		return last;
	endfunction : prescaleLast
endpackage : timer_pair_pkg

// ==== core/tick_if.sv ====
`timescale 1ns/1ps
// prescaler control and tick between the core and a prescaler
interface tick_if;
	logic [1:0] sel;
	logic inPulse;
	logic clear;
	logic tick;
	modport prescaler (input sel, input inPulse, input clear, output tick);
	modport user (output sel, output inPulse, output clear, input tick);
endinterface : tick_if

// ==== core/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic pin,
	output logic level,
	output logic rise
);
	logic stage1;
	logic stage2;
	logic stage3;

	// two-flop synchroniser plus a history flop for edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// edges seen only on synchronised stages
	assign level = stage2;
	assign rise = stage2 & ~stage3;
endmodule : pin_sync

// ==== core/timer_prescaler.sv ====
`timescale 1ns/1ps
module timer_prescaler
	import timer_pair_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	tick_if.prescaler ps
);
	logic [PS_W-1:0] cnt;

	// divide qualified input pulses by the selected ratio
	always_ff @(posedge clk) begin
		if (rst || ps.clear) begin
			cnt <= LAST_DIV1;
		end else if (ps.inPulse) begin
			if (cnt == prescaleLast(ps.sel)) begin
				cnt <= LAST_DIV1;
			end else begin
				cnt <= cnt + 8'h01;
			end
		end
	end

	assign ps.tick = ps.inPulse && (cnt == prescaleLast(ps.sel));

	property p_ps_last;
		@(posedge clk) disable iff (rst)
		ps.tick |-> cnt == prescaleLast(ps.sel);
	endproperty
	a_ps_last: assert property (p_ps_last) else $error("tick off ratio");

	property p_ps_gap;
		@(posedge clk) disable iff (rst)
		(ps.tick && ps.sel != PS_DIV1) |=>
			(!ps.tick || ps.clear || ps.sel == PS_DIV1);
	endproperty
	a_ps_gap: assert property (p_ps_gap) else $error("ticks too close");
endmodule : timer_prescaler

// ==== core/cascadable_timer_pair.sv ====
// Contract
// - join bit makes one 32-bit counter
// - high timer holds upper count word
// - joined: low controls govern, high ignored; code still obeys the high idle stop bit
// - joined: high interrupt bits used only
// - only fixed low/high pairs join
// - joined supports timer, gated, counter modes
// - 32-bit period from both period words
// - count readable as high:low pair
// - run bit starts pair or single timer
// - gate bit active only on internal clock
// - prescale divides by 1, 8, 64, 256
// - joined prescale from low timer field
// - only first pair raises DMA triggers
// - timer and gated use instruction clock
// - counter mode counts external pin edges
// - low timer syncs after its prescaler
// - high timer syncs before its prescaler
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module cascadable_timer_pair
	import timer_pair_pkg::*;
#(
	parameter int PAIR_INDEX = 0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	input wire logic cpuIdle,
	input wire logic extClkPinLow,
	input wire logic extClkPinHigh,
	output logic lowIrqReq,
	output logic highIrqReq,
	output logic [PRIO_W-1:0] lowIrqPrio,
	output logic [PRIO_W-1:0] highIrqPrio,
	output logic dmaTrigLow,
	output logic dmaTrigHigh
);
	logic [DATA_W-1:0] lowWordTimerControl;
	logic [DATA_W-1:0] highWordTimerControl;
	logic [DATA_W-1:0] lowCount;
	logic [DATA_W-1:0] highCount;
	logic [DATA_W-1:0] lowPeriod;
	logic [DATA_W-1:0] highPeriod;
	logic [IRQ_CTL_W-1:0] irqCtl;
	logic [1:0] flags;
	logic [DATA_W-1:0] readVal;
	logic lowLevel;
	logic lowRise;
	logic highLevel;
	logic highRise;
	logic lowSrc;
	logic highSrc;
	logic lowRun;
	logic highRun;
	logic joined;
	logic lowTickReg;
	logic lowTick;
	logic highTick;
	logic lowMatch;
	logic highMatch;
	logic match32;
	logic lowEvent;
	logic highEvent;
	logic [31:0] count32;
	logic [31:0] period32;
	logic [31:0] next32;

	tick_if lowPs ();
	tick_if highPs ();

	// pins pass two flops before anything reads them
	pin_sync lowSync (
		.clk(clk),
		.rst(rst),
		.pin(extClkPinLow),
		.level(lowLevel),
		.rise(lowRise)
	);

	pin_sync highSync (
		.clk(clk),
		.rst(rst),
		.pin(extClkPinHigh),
		.level(highLevel),
		.rise(highRise)
	);

	timer_prescaler lowDiv (
		.clk(clk),
		.rst(rst),
		.ps(lowPs.prescaler)
	);

	timer_prescaler highDiv (
		.clk(clk),
		.rst(rst),
		.ps(highPs.prescaler)
	);

	// join select
	// the pairing is fixed by structure: this low timer with this high one
	assign joined = lowWordTimerControl[JOIN_BIT];

	// run gating
	// joined pair obeys low run bit; high idle stop still applies
	assign lowRun = lowWordTimerControl[RUN_BIT]
		& ~(cpuIdle & lowWordTimerControl[IDLE_STOP_BIT])
		& ~(joined & cpuIdle & highWordTimerControl[IDLE_STOP_BIT]);
	assign highRun = highWordTimerControl[RUN_BIT]
		& ~(cpuIdle & highWordTimerControl[IDLE_STOP_BIT]);

	// low input source
	// internal clock is every cycle; gate qualifies it by the pin level
	always_comb begin
		lowSrc = 1'b1;
		if (lowWordTimerControl[CLK_SRC_BIT]) begin
			lowSrc = lowRise;
		end else if (lowWordTimerControl[GATE_BIT]) begin
			lowSrc = lowLevel;
		end
	end

	// high input source, used only while independent
	always_comb begin
		highSrc = 1'b1;
		if (highWordTimerControl[CLK_SRC_BIT]) begin
			highSrc = highRise;
		end else if (highWordTimerControl[GATE_BIT]) begin
			highSrc = highLevel;
		end
	end

	// low prescaler also serves the joined pair
	assign lowPs.sel = lowWordTimerControl[PS_HI:PS_LO];
	assign lowPs.inPulse = lowRun & lowSrc;
	assign lowPs.clear = ~lowRun;

	// high prescaler held idle while joined
	assign highPs.sel = highWordTimerControl[PS_HI:PS_LO];
	assign highPs.inPulse = highRun & ~joined & highSrc;
	assign highPs.clear = ~highRun | joined;

	// external ticks realigned after the low prescaler
	always_ff @(posedge clk) begin
		if (rst) begin
			lowTickReg <= 1'b0;
		end else begin
			lowTickReg <= lowPs.tick & lowWordTimerControl[CLK_SRC_BIT];
		end
	end

	assign lowTick = lowRun & (lowWordTimerControl[CLK_SRC_BIT] ?
		lowTickReg : lowPs.tick);
	// high edges already synchronised ahead of its prescaler
	assign highTick = highPs.tick;

	// 32-bit view of count and period
	assign count32 = {highCount, lowCount};
	assign period32 = {highPeriod, lowPeriod};
	assign match32 = count32 == period32;
	assign next32 = match32 ? 32'h0000_0000 : count32 + 32'h0000_0001;
	assign lowMatch = lowCount == lowPeriod;
	assign highMatch = highCount == highPeriod;

	// period events; joined events are high-timer events
	assign lowEvent = lowTick & ~joined & lowMatch;
	assign highEvent = joined ? (lowTick & match32) : (highTick & highMatch);

	// control registers keep only implemented bits
	always_ff @(posedge clk) begin
		if (rst) begin
			lowWordTimerControl <= CTL_RESET;
			highWordTimerControl <= CTL_RESET;
		end else if (wr) begin
			if (addr == ADDR_LOW_CTL) begin
				lowWordTimerControl <= wdata & LOW_CTL_MASK;
			end else if (addr == ADDR_HIGH_CTL) begin
				highWordTimerControl <= wdata & HIGH_CTL_MASK;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lowPeriod <= PERIOD_RESET;
			highPeriod <= PERIOD_RESET;
		end else if (wr) begin
			if (addr == ADDR_LOW_PERIOD) begin
				lowPeriod <= wdata;
			end else if (addr == ADDR_HIGH_PERIOD) begin
				highPeriod <= wdata;
			end
		end
	end

	// low count word; a software load wins over a tick
	always_ff @(posedge clk) begin
		if (rst) begin
			lowCount <= COUNT_RESET;
		end else if (wr && addr == ADDR_LOW_COUNT) begin
			lowCount <= wdata;
		end else if (lowTick) begin
			if (joined) begin
				lowCount <= next32[15:0];
			end else if (lowMatch) begin
				lowCount <= WORD_ZERO;
			end else begin
				lowCount <= lowCount + WORD_ONE;
			end
		end
	end

	// high count word carries the upper half when joined
	always_ff @(posedge clk) begin
		if (rst) begin
			highCount <= COUNT_RESET;
		end else if (wr && addr == ADDR_HIGH_COUNT) begin
			highCount <= wdata;
		end else if (joined) begin
			if (lowTick) begin
				highCount <= next32[31:16];
			end
		end else if (highTick) begin
			if (highMatch) begin
				highCount <= WORD_ZERO;
			end else begin
				highCount <= highCount + WORD_ONE;
			end
		end
	end

	// interrupt enables and priorities
	always_ff @(posedge clk) begin
		if (rst) begin
			irqCtl <= IRQ_CTL_RESET;
		end else if (wr && addr == ADDR_IRQ_CTL) begin
			irqCtl <= wdata[IRQ_CTL_W-1:0];
		end
	end

	// sticky flags: writing 0 clears, a same-cycle event still sets
	always_ff @(posedge clk) begin
		if (rst) begin
			flags <= FLAG_RESET;
		end else if (wr && addr == ADDR_IRQ_FLAG) begin
			flags <= (flags & wdata[1:0]) | {highEvent, lowEvent};
		end else begin
			flags <= flags | {highEvent, lowEvent};
		end
	end

	// joined pair drives only the high interrupt request
	always_ff @(posedge clk) begin
		if (rst) begin
			lowIrqReq <= 1'b0;
			highIrqReq <= 1'b0;
			lowIrqPrio <= '0;
			highIrqPrio <= '0;
		end else begin
			lowIrqReq <= flags[FLAG_LOW] & irqCtl[LOW_IE_BIT] & ~joined;
			highIrqReq <= flags[FLAG_HIGH] & irqCtl[HIGH_IE_BIT];
			lowIrqPrio <= irqCtl[LOW_PRIO_LO +: PRIO_W];
			highIrqPrio <= irqCtl[HIGH_PRIO_LO +: PRIO_W];
		end
	end

	// DMA triggers exist only on the first pair
	always_ff @(posedge clk) begin
		if (rst) begin
			dmaTrigLow <= 1'b0;
			dmaTrigHigh <= 1'b0;
		end else begin
			dmaTrigLow <= (PAIR_INDEX == 0) && lowEvent;
			dmaTrigHigh <= (PAIR_INDEX == 0) && highEvent;
		end
	end

	always_comb begin
		readVal = WORD_ZERO;
		if (addr == ADDR_LOW_CTL) begin
			readVal = lowWordTimerControl;
		end else if (addr == ADDR_HIGH_CTL) begin
			readVal = highWordTimerControl;
		end else if (addr == ADDR_LOW_COUNT) begin
			readVal = lowCount;
		end else if (addr == ADDR_HIGH_COUNT) begin
			readVal = highCount;
		end else if (addr == ADDR_LOW_PERIOD) begin
			readVal = lowPeriod;
		end else if (addr == ADDR_HIGH_PERIOD) begin
			readVal = highPeriod;
		end else if (addr == ADDR_IRQ_CTL) begin
			readVal = {8'h00, irqCtl};
		end else if (addr == ADDR_IRQ_FLAG) begin
			readVal = {14'h0000, flags};
		end
	end

	// read data stand for one cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= WORD_ZERO;
		end else if (rd) begin
			rdata <= readVal;
		end else begin
			rdata <= WORD_ZERO;
		end
	end

	// checks on counting, joining and register behaviour
	sequence s_wrapped;
		count32 == 32'h0000_0000 ##0 flags[FLAG_HIGH];
	endsequence

	property p_wrap32;
		@(posedge clk) disable iff (rst)
		(joined && lowTick && match32 && !wr) |=> s_wrapped;
	endproperty
	a_wrap32: assert property (p_wrap32) else $error("pair did not wrap");

	property p_carry;
		@(posedge clk) disable iff (rst)
		(joined && lowTick && !match32 && lowCount == 16'hffff && !wr) |=>
			highCount == $past(highCount) + WORD_ONE;
	endproperty
	a_carry: assert property (p_carry) else $error("no carry to high");

	property p_wrap16;
		@(posedge clk) disable iff (rst)
		(!joined && lowTick && lowMatch && !wr) |=>
			(lowCount == WORD_ZERO && flags[FLAG_LOW]);
	endproperty
	a_wrap16: assert property (p_wrap16) else $error("low did not wrap");

	property p_low_flag_quiet;
		@(posedge clk) disable iff (rst)
		(joined && !flags[FLAG_LOW]) |=> !flags[FLAG_LOW];
	endproperty
	a_low_flag_quiet: assert property (p_low_flag_quiet) else $error("low flag set");

	property p_high_idle;
		@(posedge clk) disable iff (rst)
		joined |-> !highTick;
	endproperty
	a_high_idle: assert property (p_high_idle) else $error("high ran joined");

	property p_stopped;
		@(posedge clk) disable iff (rst)
		(joined && !lowWordTimerControl[RUN_BIT] && !wr) |=>
			count32 == $past(count32);
	endproperty
	a_stopped: assert property (p_stopped) else $error("pair ran stopped");

	property p_gate;
		@(posedge clk) disable iff (rst)
		(!lowWordTimerControl[CLK_SRC_BIT] &&
			lowWordTimerControl[GATE_BIT] && !lowLevel) |-> !lowPs.inPulse;
	endproperty
	a_gate: assert property (p_gate) else $error("counted gate low");

	property p_ext_align;
		@(posedge clk) disable iff (rst)
		(lowWordTimerControl[CLK_SRC_BIT] && lowPs.tick && !wr) |=>
			lowTickReg;
	endproperty
	a_ext_align: assert property (p_ext_align) else $error("tick not realigned");

	property p_ctl_zero;
		@(posedge clk) disable iff (rst)
		(rd && addr == ADDR_LOW_CTL) |=> (rdata & ~LOW_CTL_MASK) == WORD_ZERO;
	endproperty
	a_ctl_zero: assert property (p_ctl_zero) else $error("reserved bit set");

	property p_dma_pair;
		@(posedge clk) disable iff (rst)
		(PAIR_INDEX != 0) |-> (!dmaTrigLow && !dmaTrigHigh);
	endproperty
	a_dma_pair: assert property (p_dma_pair) else $error("dma on wrong pair");
endmodule : cascadable_timer_pair

// ==== sim/ext_pin_model.sv ====
`timescale 1ns/1ps
// far side of a timer pin: clock pulses or a gate level, idles low
module ext_pin_model (
	input wire logic clk,
	output logic pin
);
	// pin rests at its pull-down level outside bursts
	initial begin
		pin = 1'b0;
	end

	// n clock pulses, three cycles high and three low each
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			pin <= 1'b1;
			repeat (3) @(posedge clk);
			pin <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask : pulses

	// gate level held high for h cycles
	task automatic hold(input int h);
		@(posedge clk);
		pin <= 1'b1;
		repeat (h) @(posedge clk);
		pin <= 1'b0;
	endtask : hold
endmodule : ext_pin_model

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
	import timer_pair_pkg::*;
	logic clk, rst, wr, rd, cpuIdle;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, v;
	logic extClkPinLow, extClkPinHigh, lowIrqReq, highIrqReq;
	logic [PRIO_W-1:0] lowIrqPrio, highIrqPrio;
	logic dmaTrigLow, dmaTrigHigh, dma2Low, dma2High;
	logic dma2Seen = 1'b0;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	cascadable_timer_pair #(.PAIR_INDEX(0)) dut (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .cpuIdle(cpuIdle),
		.extClkPinLow(extClkPinLow), .extClkPinHigh(extClkPinHigh),
		.lowIrqReq(lowIrqReq), .highIrqReq(highIrqReq),
		.lowIrqPrio(lowIrqPrio), .highIrqPrio(highIrqPrio),
		.dmaTrigLow(dmaTrigLow), .dmaTrigHigh(dmaTrigHigh)
	);
	// a second pair, same traffic, must never trigger dma
	cascadable_timer_pair #(.PAIR_INDEX(1)) pairTwo (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(), .cpuIdle(cpuIdle),
		.extClkPinLow(extClkPinLow), .extClkPinHigh(extClkPinHigh),
		.lowIrqReq(), .highIrqReq(), .lowIrqPrio(), .highIrqPrio(),
		.dmaTrigLow(dma2Low), .dmaTrigHigh(dma2High)
	);
	ext_pin_model lowPin (.clk(clk), .pin(extClkPinLow));
	ext_pin_model highPin (.clk(clk), .pin(extClkPinHigh));

	// 40 ns clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// hang guard and dma watch on the second pair
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (dma2Low === 1'b1 || dma2High === 1'b1) dma2Seen <= 1'b1;
		if (cycles == 90000) begin
			n_errors++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done

	task automatic check(input string what, input logic [31:0] got,
		input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wrReg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wrReg

	task automatic rdReg(input logic [ADDR_W-1:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rdReg

	// cycles between two successive period events of one word
	task automatic gap(input bit hi, output int n);
		n = 0;
		while ((hi ? dmaTrigHigh : dmaTrigLow) !== 1'b1 && n < 70000) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		n = 1;
		while ((hi ? dmaTrigHigh : dmaTrigLow) !== 1'b1 && n < 70000) begin
			@(negedge clk);
			n++;
		end
	endtask : gap

	task automatic t_regs();
		logic [15:0] exp [8] = '{CTL_RESET, CTL_RESET, COUNT_RESET,
			COUNT_RESET, PERIOD_RESET, PERIOD_RESET, 16'h0000, 16'h0000};
		for (int i = 0; i < 8; i++) begin
			rdReg(3'(i), v);
			check("reset value", v, exp[i]);
		end
		wrReg(ADDR_LOW_CTL, 16'h7fff);
		rdReg(ADDR_LOW_CTL, v);
		check("low ctl mask", v, 16'h207a);
		wrReg(ADDR_HIGH_CTL, 16'h7fff);
		rdReg(ADDR_HIGH_CTL, v);
		check("high ctl mask", v, 16'h2072);
		wrReg(ADDR_LOW_CTL, CTL_RESET);
		wrReg(ADDR_HIGH_CTL, CTL_RESET);
		$display("test registers done");
	endtask : t_regs

	task automatic t_prescale();
		int n;
		int div [4] = '{1, 8, 64, 256};
		for (int c = 0; c < 4; c++) begin
			wrReg(ADDR_LOW_CTL, 16'(c) << PS_LO);
			wrReg(ADDR_LOW_PERIOD, WORD_ONE);
			wrReg(ADDR_IRQ_CTL, 16'h0001);
			wrReg(ADDR_LOW_CTL, 16'h8000 | (16'(c) << PS_LO));
			gap(1'b0, n);
			check("prescaled period", n, 2 * div[c]);
			wrReg(ADDR_LOW_CTL, CTL_RESET);
		end
		rdReg(ADDR_IRQ_FLAG, v);
		check("low flag", v[FLAG_LOW], 1'b1);
		check("low irq", lowIrqReq, 1'b1);
		$display("test prescaler done");
	endtask : t_prescale

	task automatic t_joined();
		int n;
		wrReg(ADDR_IRQ_FLAG, WORD_ZERO);
		// high controls set to slow values that must be ignored
		wrReg(ADDR_HIGH_CTL, 16'h0030);
		wrReg(ADDR_LOW_CTL, 16'h0008);
		wrReg(ADDR_LOW_PERIOD, WORD_ZERO);
		wrReg(ADDR_HIGH_PERIOD, 16'h0002);
		wrReg(ADDR_IRQ_CTL, 16'h00af);
		wrReg(ADDR_LOW_COUNT, 16'hfffd);
		wrReg(ADDR_HIGH_COUNT, WORD_ZERO);
		wrReg(ADDR_LOW_CTL, 16'h8008);
		repeat (10) @(posedge clk);
		wrReg(ADDR_LOW_CTL, 16'h0008);
		rdReg(ADDR_HIGH_COUNT, v);
		check("carry to high word", v, WORD_ONE);
		// period 0x10000 gives an event every 65537 ticks
		wrReg(ADDR_HIGH_PERIOD, WORD_ONE);
		wrReg(ADDR_HIGH_COUNT, WORD_ZERO);
		wrReg(ADDR_LOW_COUNT, 16'hfffd);
		wrReg(ADDR_LOW_CTL, 16'h8008);
		gap(1'b1, n);
		check("joined period", n, 32'h10001);
		check("low irq joined", lowIrqReq, 1'b0);
		check("high irq joined", highIrqReq, 1'b1);
		check("high prio", highIrqPrio, 3'h5);
		check("low prio", lowIrqPrio, 3'h3);
		wrReg(ADDR_LOW_CTL, 16'h0008);
		wrReg(ADDR_HIGH_CTL, 16'h2030);
		wrReg(ADDR_LOW_COUNT, WORD_ZERO);
		@(posedge clk);
		cpuIdle <= 1'b1;
		wrReg(ADDR_LOW_CTL, 16'h8008);
		repeat (5) @(posedge clk);
		wrReg(ADDR_LOW_CTL, 16'h0008);
		cpuIdle <= 1'b0;
		rdReg(ADDR_LOW_COUNT, v);
		check("idle stop joined", v, WORD_ZERO);
		$display("test joined done");
	endtask : t_joined

	task automatic t_counter();
		wrReg(ADDR_LOW_CTL, 16'h004a);
		wrReg(ADDR_LOW_PERIOD, PERIOD_RESET);
		wrReg(ADDR_HIGH_PERIOD, PERIOD_RESET);
		wrReg(ADDR_LOW_COUNT, WORD_ZERO);
		wrReg(ADDR_HIGH_COUNT, WORD_ZERO);
		wrReg(ADDR_LOW_CTL, 16'h804a);
		lowPin.pulses(5);
		repeat (8) @(posedge clk);
		wrReg(ADDR_LOW_CTL, 16'h004a);
		rdReg(ADDR_LOW_COUNT, v);
		check("joined pin count", v, 16'h0005);
		rdReg(ADDR_HIGH_COUNT, v);
		check("joined high word", v, WORD_ZERO);
		// split pair: the high timer counts its own pin
		wrReg(ADDR_LOW_CTL, CTL_RESET);
		wrReg(ADDR_HIGH_CTL, 16'h8002);
		highPin.pulses(4);
		repeat (8) @(posedge clk);
		wrReg(ADDR_HIGH_CTL, CTL_RESET);
		rdReg(ADDR_HIGH_COUNT, v);
		check("high pin count", v, 16'h0004);
		$display("test counter done");
	endtask : t_counter

	task automatic t_gate();
		wrReg(ADDR_LOW_COUNT, WORD_ZERO);
		wrReg(ADDR_LOW_CTL, 16'h0040);
		wrReg(ADDR_LOW_CTL, 16'h8040);
		lowPin.hold(7);
		repeat (8) @(posedge clk);
		wrReg(ADDR_LOW_CTL, CTL_RESET);
		rdReg(ADDR_LOW_COUNT, v);
		check("gated count", v, 16'h0007);
		check("second pair dma", dma2Seen, 1'b0);
		$display("test gate done");
	endtask : t_gate

	// reset, then the scenarios in turn
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = '0;
		cpuIdle = 1'b0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_prescale();
		t_joined();
		t_counter();
		t_gate();
		test_done();
	end
endmodule : tb
